// ==== include/vdcc_pkg.sv ====
// Constants, field layouts and carrier types for the video decoder channel control bank.
package vdcc_pkg;

  localparam int unsigned VDCC_CHANNELS  = 4;
  localparam int unsigned VDCC_ADDR_W    = 8;
  localparam int unsigned VDCC_DATA_W    = 8;
  localparam logic [1:0]  VDCC_CH_LSB    = 2'h0;

  // Register indices within one channel quarter.
  localparam logic [5:0] VDCC_REG_STATUS  = 6'h00;
  localparam logic [5:0] VDCC_REG_STD     = 6'h01;
  localparam logic [5:0] VDCC_REG_LOOP    = 6'h02;
  localparam logic [5:0] VDCC_REG_XHS     = 6'h03;
  localparam logic [5:0] VDCC_REG_XHL     = 6'h04;
  localparam logic [5:0] VDCC_REG_YHS     = 6'h05;
  localparam logic [5:0] VDCC_REG_YHL     = 6'h06;
  localparam logic [5:0] VDCC_REG_HHIGH   = 6'h07;
  localparam logic [5:0] VDCC_REG_HSW     = 6'h08;
  localparam logic [5:0] VDCC_REG_XVS     = 6'h09;
  localparam logic [5:0] VDCC_REG_XVL     = 6'h0a;
  localparam logic [5:0] VDCC_REG_YVS     = 6'h0b;
  localparam logic [5:0] VDCC_REG_YVL     = 6'h0c;
  localparam logic [5:0] VDCC_REG_VHIGH   = 6'h0d;
  localparam logic [5:0] VDCC_REG_SYNC    = 6'h0e;
  localparam logic [5:0] VDCC_REG_HUE     = 6'h0f;
  localparam logic [5:0] VDCC_REG_SAT     = 6'h10;
  localparam logic [5:0] VDCC_REG_CONTRAST_ADJUST    = 6'h11;
  localparam logic [5:0] VDCC_REG_BRT     = 6'h12;
  localparam logic [5:0] VDCC_REG_CHROMA  = 6'h13;

  // Reset values of the fields.
  localparam logic [9:0] VDCC_RST_HSTART  = 10'h020;
  localparam logic [9:0] VDCC_RST_HLEN    = 10'h2d0;
  localparam logic [5:0] VDCC_RST_HSW     = 6'h20;
  localparam logic [8:0] VDCC_RST_VSTART  = 9'h006;
  localparam logic [8:0] VDCC_RST_VLINES  = 9'h0f0;
  localparam logic [2:0] VDCC_RST_PLLSPD  = 3'h4;
  localparam logic [7:0] VDCC_RST_MID     = 8'h80;
  localparam logic [1:0] VDCC_RST_LOOPSPD = 2'h1;
  localparam logic [1:0] VDCC_RST_CHROMA_LOWPASS_SEL    = 2'h1;
  localparam logic [1:0] VDCC_RST_ACC     = 2'h3;
  localparam logic [2:0] VDCC_RST_STD     = 3'h0;

  // Fixed bits that read back from the standard, loop and sync control registers.
  localparam logic [1:0] VDCC_LOOP_FIXED  = 2'h2;
  localparam logic [1:0] VDCC_STD_FIXED   = 2'h1;
  localparam logic [1:0] VDCC_SYNC_FIXED  = 2'h2;

  // Status inputs of one channel from the decoder core.
  typedef struct packed {
    logic color_present_flag;
    logic color_locked;
    logic gain_locked;
    logic clamp_loop_locked;
    logic line_pll_locked;
    logic field_rate_flag;
    logic nonstandard_flag;
  } vdcc_status_t;

  // Decoder settings of one channel.
  typedef struct packed {
    logic       manual_standard_sel;
    logic [2:0] standard_code;
    logic       agc_enable;
    logic       setup_level_sel;
    logic [1:0] gain_loop_speed;
    logic [1:0] offset_loop_speed;
    logic [9:0] x_h_window_start;
    logic [9:0] x_h_window_length;
    logic [9:0] y_h_window_start;
    logic [9:0] y_h_window_length;
    logic [5:0] line_sync_width;
    logic [8:0] x_v_window_start;
    logic [8:0] x_v_window_lines;
    logic [8:0] y_v_window_start;
    logic [8:0] y_v_window_lines;
    logic       line_pll_manual;
    logic [2:0] line_pll_speed;
    logic [1:0] field_flag_source;
    logic       frame_sync_align;
    logic       field_flag_polarity;
    logic       line_sync_polarity;
    logic       frame_sync_polarity;
    logic [7:0] hue;
    logic [7:0] chroma_gain;
    logic [7:0] luma_gain;
    logic [7:0] luma_offset;
    logic [1:0] if_comp_sel;
    logic [1:0] chroma_lowpass_sel;
    logic [1:0] acc_loop_speed;
    logic [1:0] apc_loop_speed;
  } vdcc_config_t;

  // Effective controls steered by the bank into the decoder core.
  typedef struct packed {
    logic       force_standard;
    logic       pll_auto_track;
    logic [2:0] pll_speed_eff;
    logic [1:0] field_accum_sel;
    logic       field_from_video;
  } vdcc_steer_t;

endpackage

// ==== logic/vdcc_bank.sv ====
// Register bank for the four channel copies of the decoder controls and status.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps

module vdcc_bank
  import vdcc_pkg::*;
#(
  parameter int unsigned CHANNELS = VDCC_CHANNELS
)
(
  input  wire logic                         clk_in,
  input  wire logic                         rst_n_in,
  input  wire logic [VDCC_ADDR_W-1:0]       addr_in,
  input  wire logic [VDCC_DATA_W-1:0]       wdata_in,
  input  wire logic                         wr_in,
  input  wire logic                         rd_in,
  output logic      [VDCC_DATA_W-1:0]       rdata_out,
  input  wire vdcc_status_t [CHANNELS-1:0]  status_in,
  input  wire logic [CHANNELS-1:0]          video_present_in,
  input  wire logic [CHANNELS-1:0]          raw_field_in,
  input  wire logic [CHANNELS-1:0]          raw_hsync_in,
  input  wire logic [CHANNELS-1:0]          raw_vsync_in,
  input  wire logic [CHANNELS-1:0]          hs_aligned_vsync_in,
  input  wire logic [CHANNELS-1:0]          hs_aligned_field_in,
  output vdcc_config_t [CHANNELS-1:0]       config_out,
  output vdcc_steer_t  [CHANNELS-1:0]       steer_out,
  output logic      [CHANNELS-1:0]          field_flag_out,
  output logic      [CHANNELS-1:0]          hsync_out,
  output logic      [CHANNELS-1:0]          vsync_out
);

  // Channel select is the top two address bits, the register index the low six.
  logic [1:0] ch_sel;
  logic [5:0] reg_idx;

  assign ch_sel  = addr_in[7:6];
  assign reg_idx = addr_in[5:0];

  vdcc_config_t [CHANNELS-1:0] cfg;
  vdcc_status_t [CHANNELS-1:0] stat_q;
  logic [CHANNELS-1:0]         fld_q;
  logic [CHANNELS-1:0]         hs_q;
  logic [CHANNELS-1:0]         vs_q;

  assign config_out = cfg;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : gen_ch
      logic wr_here;

      // The genvar is cast rather than sliced, which a strict front end refuses.
      assign wr_here = wr_in && (ch_sel == 2'(g));

      // Software writes to this channel's settings; status is not writable.
      always_ff @(posedge clk_in or negedge rst_n_in)
      begin
        if (!rst_n_in)
        begin
          cfg[g].manual_standard_sel <= 1'b0;
          cfg[g].standard_code       <= VDCC_RST_STD;
          cfg[g].agc_enable          <= 1'b0;
          cfg[g].setup_level_sel     <= 1'b0;
          cfg[g].gain_loop_speed     <= VDCC_RST_LOOPSPD;
          cfg[g].offset_loop_speed   <= VDCC_RST_LOOPSPD;
          cfg[g].x_h_window_start    <= VDCC_RST_HSTART;
          cfg[g].y_h_window_start    <= VDCC_RST_HSTART;
          cfg[g].x_h_window_length   <= VDCC_RST_HLEN;
          cfg[g].y_h_window_length   <= VDCC_RST_HLEN;
          cfg[g].line_sync_width     <= VDCC_RST_HSW;
          cfg[g].x_v_window_start    <= VDCC_RST_VSTART;
          cfg[g].y_v_window_start    <= VDCC_RST_VSTART;
          cfg[g].x_v_window_lines    <= VDCC_RST_VLINES;
          cfg[g].y_v_window_lines    <= VDCC_RST_VLINES;
          cfg[g].line_pll_manual     <= 1'b0;
          cfg[g].line_pll_speed      <= VDCC_RST_PLLSPD;
          cfg[g].field_flag_source   <= 2'h0;
          cfg[g].frame_sync_align    <= 1'b0;
          cfg[g].field_flag_polarity <= 1'b0;
          cfg[g].line_sync_polarity  <= 1'b0;
          cfg[g].frame_sync_polarity <= 1'b0;
          cfg[g].hue                 <= VDCC_RST_MID;
          cfg[g].chroma_gain         <= VDCC_RST_MID;
          cfg[g].luma_gain           <= VDCC_RST_MID;
          cfg[g].luma_offset         <= VDCC_RST_MID;
          cfg[g].if_comp_sel         <= 2'h0;
          cfg[g].chroma_lowpass_sel  <= VDCC_RST_CHROMA_LOWPASS_SEL;
          cfg[g].acc_loop_speed      <= VDCC_RST_ACC;
          cfg[g].apc_loop_speed      <= VDCC_RST_ACC;
        end
        else if (wr_here)
        begin
          unique case (reg_idx)
            VDCC_REG_STD:
            begin
              cfg[g].manual_standard_sel <= wdata_in[7];
              cfg[g].standard_code       <= wdata_in[6:4];
            end
            VDCC_REG_LOOP:
            begin
              cfg[g].agc_enable        <= wdata_in[7];
              cfg[g].setup_level_sel   <= wdata_in[6];
              cfg[g].gain_loop_speed   <= wdata_in[3:2];
              cfg[g].offset_loop_speed <= wdata_in[1:0];
            end
            VDCC_REG_XHS:   cfg[g].x_h_window_start[7:0]  <= wdata_in;
            VDCC_REG_XHL:   cfg[g].x_h_window_length[7:0] <= wdata_in;
            VDCC_REG_YHS:   cfg[g].y_h_window_start[7:0]  <= wdata_in;
            VDCC_REG_YHL:   cfg[g].y_h_window_length[7:0] <= wdata_in;
            VDCC_REG_HHIGH:
            begin
              cfg[g].y_h_window_length[9:8] <= wdata_in[7:6];
              cfg[g].y_h_window_start[9:8]  <= wdata_in[5:4];
              cfg[g].x_h_window_length[9:8] <= wdata_in[3:2];
              cfg[g].x_h_window_start[9:8]  <= wdata_in[1:0];
            end
            VDCC_REG_HSW:   cfg[g].line_sync_width <= wdata_in[5:0];
            VDCC_REG_XVS:   cfg[g].x_v_window_start[7:0] <= wdata_in;
            VDCC_REG_XVL:   cfg[g].x_v_window_lines[7:0] <= wdata_in;
            // Path Y limits are left to software; values are stored as written.
            VDCC_REG_YVS:   cfg[g].y_v_window_start[7:0] <= wdata_in;
            VDCC_REG_YVL:   cfg[g].y_v_window_lines[7:0] <= wdata_in;
            VDCC_REG_VHIGH:
            begin
              cfg[g].line_pll_manual     <= wdata_in[7];
              cfg[g].line_pll_speed      <= wdata_in[6:4];
              cfg[g].y_v_window_lines[8] <= wdata_in[3];
              cfg[g].y_v_window_start[8] <= wdata_in[2];
              cfg[g].x_v_window_lines[8] <= wdata_in[1];
              cfg[g].x_v_window_start[8] <= wdata_in[0];
            end
            VDCC_REG_SYNC:
            begin
              cfg[g].field_flag_source   <= wdata_in[7:6];
              cfg[g].frame_sync_align    <= wdata_in[5];
              cfg[g].field_flag_polarity <= wdata_in[4];
              cfg[g].line_sync_polarity  <= wdata_in[3];
              cfg[g].frame_sync_polarity <= wdata_in[2];
            end
            VDCC_REG_HUE:   cfg[g].hue         <= wdata_in;
            VDCC_REG_SAT:   cfg[g].chroma_gain <= wdata_in;
            VDCC_REG_CONTRAST_ADJUST:  cfg[g].luma_gain   <= wdata_in;
            VDCC_REG_BRT:   cfg[g].luma_offset <= wdata_in;
            VDCC_REG_CHROMA:
            begin
              cfg[g].if_comp_sel        <= wdata_in[7:6];
              cfg[g].chroma_lowpass_sel <= wdata_in[5:4];
              cfg[g].acc_loop_speed     <= wdata_in[3:2];
              cfg[g].apc_loop_speed     <= wdata_in[1:0];
            end
            default:
            begin
            end
          endcase
        end
      end

      // Status is registered once so a read sees a stable snapshot.
      always_ff @(posedge clk_in or negedge rst_n_in)
      begin
        if (!rst_n_in)
          stat_q[g] <= '0;
        else
          stat_q[g] <= status_in[g];
      end

      // Standard, PLL and field source steering into the decoder core.
      always_comb
      begin
        // Without video the chosen standard is used for free-running as well.
        steer_out[g].force_standard   = cfg[g].manual_standard_sel
                                        || !video_present_in[g];
        steer_out[g].pll_auto_track   = !cfg[g].line_pll_manual;
        steer_out[g].pll_speed_eff    = cfg[g].line_pll_speed;
        steer_out[g].field_accum_sel  = cfg[g].field_flag_source;
        steer_out[g].field_from_video = (cfg[g].field_flag_source == 2'h0);
      end

      // Sync and field outputs: pick the alignment for frame sync and field, then apply polarity.
      // Raw syncs are active high; raw field is high in odd fields.
      always_ff @(posedge clk_in or negedge rst_n_in)
      begin
        if (!rst_n_in)
        begin
          fld_q[g] <= 1'b0;
          hs_q[g]  <= 1'b1;
          vs_q[g]  <= 1'b1;
        end
        else
        begin
          fld_q[g] <= (cfg[g].frame_sync_align ? hs_aligned_field_in[g] : raw_field_in[g])
                      ^ cfg[g].field_flag_polarity;
          hs_q[g]  <= raw_hsync_in[g] ~^ cfg[g].line_sync_polarity;
          vs_q[g]  <= (cfg[g].frame_sync_align ? hs_aligned_vsync_in[g] : raw_vsync_in[g])
                      ~^ cfg[g].frame_sync_polarity;
        end
      end
    end
  endgenerate

  assign field_flag_out = fld_q;
  assign hsync_out      = hs_q;
  assign vsync_out      = vs_q;

  // Read mux; unmapped indices read zero.
  logic [VDCC_DATA_W-1:0] next_rdata;

  always_comb
  begin
    vdcc_config_t c;
    vdcc_status_t s;
    c = cfg[ch_sel];
    s = stat_q[ch_sel];
    next_rdata = '0;
    unique case (reg_idx)
      VDCC_REG_STATUS: next_rdata = {3'h0, s.color_present_flag, s.color_locked,
                                     s.gain_locked, s.clamp_loop_locked,
                                     s.line_pll_locked};
      VDCC_REG_STD:    next_rdata = {c.manual_standard_sel, c.standard_code,
                                     VDCC_STD_FIXED, s.nonstandard_flag,
                                     s.field_rate_flag};
      VDCC_REG_LOOP:   next_rdata = {c.agc_enable, c.setup_level_sel, VDCC_LOOP_FIXED,
                                     c.gain_loop_speed, c.offset_loop_speed};
      VDCC_REG_XHS:    next_rdata = c.x_h_window_start[7:0];
      VDCC_REG_XHL:    next_rdata = c.x_h_window_length[7:0];
      VDCC_REG_YHS:    next_rdata = c.y_h_window_start[7:0];
      VDCC_REG_YHL:    next_rdata = c.y_h_window_length[7:0];
      VDCC_REG_HHIGH:  next_rdata = {c.y_h_window_length[9:8], c.y_h_window_start[9:8],
                                     c.x_h_window_length[9:8], c.x_h_window_start[9:8]};
      VDCC_REG_HSW:    next_rdata = {2'h0, c.line_sync_width};
      VDCC_REG_XVS:    next_rdata = c.x_v_window_start[7:0];
      VDCC_REG_XVL:    next_rdata = c.x_v_window_lines[7:0];
      VDCC_REG_YVS:    next_rdata = c.y_v_window_start[7:0];
      VDCC_REG_YVL:    next_rdata = c.y_v_window_lines[7:0];
      VDCC_REG_VHIGH:  next_rdata = {c.line_pll_manual, c.line_pll_speed,
                                     c.y_v_window_lines[8], c.y_v_window_start[8],
                                     c.x_v_window_lines[8], c.x_v_window_start[8]};
      VDCC_REG_SYNC:   next_rdata = {c.field_flag_source, c.frame_sync_align,
                                     c.field_flag_polarity, c.line_sync_polarity,
                                     c.frame_sync_polarity, VDCC_SYNC_FIXED};
      VDCC_REG_HUE:    next_rdata = c.hue;
      VDCC_REG_SAT:    next_rdata = c.chroma_gain;
      VDCC_REG_CONTRAST_ADJUST:   next_rdata = c.luma_gain;
      VDCC_REG_BRT:    next_rdata = c.luma_offset;
      VDCC_REG_CHROMA: next_rdata = {c.if_comp_sel, c.chroma_lowpass_sel,
                                     c.acc_loop_speed, c.apc_loop_speed};
      default:         next_rdata = '0;
    endcase
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rdata_out <= '0;
    else if (rd_in)
      rdata_out <= next_rdata;
    else
      rdata_out <= '0;
  end

endmodule

// ==== testbench/vdcc_checker.sv ====
// Concurrent checks on the ports of the decoder channel control bank.
`timescale 1ns/1ps

module vdcc_checker
  import vdcc_pkg::*;
#(
  parameter int unsigned CHANNELS = VDCC_CHANNELS
)
(
  input wire logic                         clk_in,
  input wire logic                         rst_n_in,
  input wire logic [VDCC_ADDR_W-1:0]       addr_in,
  input wire logic [VDCC_DATA_W-1:0]       wdata_in,
  input wire logic                         wr_in,
  input wire logic                         rd_in,
  input wire logic [VDCC_DATA_W-1:0]       rdata_out,
  input wire vdcc_status_t [CHANNELS-1:0]  status_in,
  input wire logic [CHANNELS-1:0]          video_present_in,
  input wire logic [CHANNELS-1:0]          raw_field_in,
  input wire logic [CHANNELS-1:0]          raw_hsync_in,
  input wire logic [CHANNELS-1:0]          raw_vsync_in,
  input wire logic [CHANNELS-1:0]          hs_aligned_vsync_in,
  input wire logic [CHANNELS-1:0]          hs_aligned_field_in,
  input wire vdcc_config_t [CHANNELS-1:0]  config_out,
  input wire vdcc_steer_t  [CHANNELS-1:0]  steer_out,
  input wire logic [CHANNELS-1:0]          field_flag_out,
  input wire logic [CHANNELS-1:0]          hsync_out,
  input wire logic [CHANNELS-1:0]          vsync_out
);
  logic vs_sel;
  logic fld_sel;

  // Frame sync and field sources that the alignment bit picks for channel 0.
  assign vs_sel = config_out[0].frame_sync_align ? hs_aligned_vsync_in[0] : raw_vsync_in[0];
  assign fld_sel = config_out[0].frame_sync_align ? hs_aligned_field_in[0] : raw_field_in[0];

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // The snapshot needs one settled cycle, so only stable status is judged.
  status_read_a: assert property (
    $past(rst_n_in) && rd_in && addr_in == 8'h40 && $stable(status_in[1])
    |=> rdata_out == {3'h0, $past(status_in[1][6:2])}) else $error("status byte wrong");
  field_rate_a: assert property (
    $past(rst_n_in) && rd_in && addr_in == 8'h41 && $stable(status_in[1])
    |=> rdata_out[1:0] == {$past(status_in[1].nonstandard_flag),
    $past(status_in[1].field_rate_flag)}) else $error("field rate bit wrong");
  hue_write_a: assert property (
    wr_in && addr_in == 8'hcf |=> config_out[3].hue == $past(wdata_in))
    else $error("hue write lost");
  force_std_a: assert property (
    steer_out[2].force_standard == (config_out[2].manual_standard_sel || !video_present_in[2]))
    else $error("standard forcing wrong");
  pll_steer_a: assert property (
    steer_out[2].pll_auto_track != config_out[2].line_pll_manual
    && steer_out[2].pll_speed_eff == config_out[2].line_pll_speed) else $error("pll steer wrong");
  fld_src_a: assert property (
    steer_out[0].field_from_video == (config_out[0].field_flag_source == 2'h0)
    && steer_out[0].field_accum_sel == config_out[0].field_flag_source)
    else $error("field source wrong");
  hsync_pol_a: assert property (
    $past(rst_n_in) |-> hsync_out[0] == ($past(raw_hsync_in[0])
    ~^ $past(config_out[0].line_sync_polarity))) else $error("line sync level wrong");
  vsync_sel_a: assert property (
    $past(rst_n_in) |-> vsync_out[0] == ($past(vs_sel)
    ~^ $past(config_out[0].frame_sync_polarity))) else $error("frame sync wrong");
  field_pol_a: assert property (
    $past(rst_n_in) && $past(config_out[0].field_flag_source) == 2'h0 |-> field_flag_out[0]
    == ($past(fld_sel) ^ $past(config_out[0].field_flag_polarity))) else $error("field flag wrong");

  cover property (wr_in && addr_in == 8'hcf);
  cover property (rd_in && addr_in == 8'h40 && status_in[1] != 7'h00);
  cover property (config_out[0].frame_sync_align && !vsync_out[0]);
endmodule

bind vdcc_bank vdcc_checker #(.CHANNELS(CHANNELS)) chk_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .status_in(status_in), .video_present_in(video_present_in), .raw_field_in(raw_field_in),
  .raw_hsync_in(raw_hsync_in), .raw_vsync_in(raw_vsync_in),
  .hs_aligned_vsync_in(hs_aligned_vsync_in), .hs_aligned_field_in(hs_aligned_field_in),
  .config_out(config_out), .steer_out(steer_out), .field_flag_out(field_flag_out),
  .hsync_out(hsync_out), .vsync_out(vsync_out));

// ==== testbench/tb_top.sv ====
// Register and sync output bench for the decoder channel control bank.
`timescale 1ns/1ps

module tb_top;
  import vdcc_pkg::*;
  logic               clk_in, rst_n_in, wr_in, rd_in;
  logic [7:0]         addr_in, wdata_in, rdata_out, d, e;
  vdcc_status_t [3:0] status_in;
  logic [3:0]         video_present_in, raw_field_in, raw_hsync_in, raw_vsync_in;
  logic [3:0]         hs_aligned_vsync_in, hs_aligned_field_in;
  logic [3:0]         field_flag_out, hsync_out, vsync_out;
  vdcc_config_t [3:0] config_out;
  vdcc_steer_t  [3:0] steer_out;
  int                 n_fail, n_tests, cyc;
  // Expected reset bytes of indices 0x00 to 0x14 of one channel.
  localparam logic [7:0] RST [0:20] = '{8'h00, 8'h04, 8'h25, 8'h20, 8'hd0, 8'h20, 8'hd0,
    8'h88, 8'h20, 8'h06, 8'hf0, 8'h06, 8'hf0, 8'h40, 8'h02, 8'h80, 8'h80, 8'h80, 8'h80,
    8'h1f, 8'h00};

  vdcc_bank uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .status_in(status_in),
    .video_present_in(video_present_in), .raw_field_in(raw_field_in),
    .raw_hsync_in(raw_hsync_in), .raw_vsync_in(raw_vsync_in),
    .hs_aligned_vsync_in(hs_aligned_vsync_in), .hs_aligned_field_in(hs_aligned_field_in),
    .config_out(config_out), .steer_out(steer_out), .field_flag_out(field_flag_out),
    .hsync_out(hsync_out), .vsync_out(vsync_out));

  // Free running 25 MHz clock.
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // A hang is cut short well after the fewer than a thousand cycles the tests need.
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  function automatic logic [7:0] pat(int i);
    return 8'h96 + 8'(i * 8'h25);
  endfunction

  task automatic chk(input string nm, input logic [9:0] ex, input logic [9:0] got);
    n_tests++;
    if (got !== ex)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Each strobe lasts one cycle; a gap cycle keeps two tasks off the same edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk($sformatf("read %h", a), {2'h0, ex}, {2'h0, rdata_out});
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    {wr_in, rd_in, addr_in, wdata_in, status_in, video_present_in} = '0;
    {raw_field_in, raw_hsync_in, raw_vsync_in, hs_aligned_vsync_in, hs_aligned_field_in} = '0;
    rst_n_in = 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int c = 0; c < 4; c++)
      for (int i = 0; i < 21; i++)
        rd({c[1:0], i[5:0]}, RST[i]);
    chk("hlen", 10'h2d0, config_out[0].x_h_window_length);
    $display("reset test done");
    for (int i = 0; i < 64; i++)
      wr({2'h3, i[5:0]}, pat(i));
    for (int i = 0; i < 64; i++)
    begin
      d = pat(i);
      case (i[5:0])
        6'h00: e = 8'h00;
        6'h01: e = {d[7:4], 4'h4};
        6'h02: e = {d[7:6], 2'h2, d[3:0]};
        6'h08: e = {2'h0, d[5:0]};
        6'h0e: e = {d[7:2], 2'h2};
        default: e = (i < 20) ? d : 8'h00;
      endcase
      rd({2'h3, i[5:0]}, e);
      rd({2'h2, i[5:0]}, (i < 21) ? RST[i] : 8'h00);
    end
    d = pat(7);
    chk("xhs", {d[1:0], pat(3)}, config_out[3].x_h_window_start);
    chk("yhl", {d[7:6], pat(6)}, config_out[3].y_h_window_length);
    d = pat(13);
    chk("xvs", {1'b0, d[0], pat(9)}, {1'b0, config_out[3].x_v_window_start});
    chk("yvl", {1'b0, d[3], pat(12)}, {1'b0, config_out[3].y_v_window_lines});
    // Path Y vertical settings as software must program them, inside the allowed ranges.
    wr(8'h4b, 8'h0e);
    wr(8'h4c, 8'hf1);
    rd(8'h4b, 8'h0e);
    rd(8'h4c, 8'hf1);
    $display("register test done");
    for (int b = 0; b < 7; b++)
    begin
      @(posedge clk_in);
      status_in[1] <= 7'h01 << b;
      rd(8'h40, (b > 1) ? 8'h01 << (b - 2) : 8'h00);
      rd(8'h41, 8'h04 | ((b == 0) ? 8'h02 : (b == 1) ? 8'h01 : 8'h00));
    end
    $display("status test done");
    for (int m = 0; m < 16; m++)
    begin
      wr(8'h0e, {2'h0, m[3:0], 2'h2});
      for (int r = 0; r < 8; r++)
      begin
        @(posedge clk_in);
        raw_hsync_in <= {4{r[0]}};
        raw_vsync_in <= {4{r[1]}};
        hs_aligned_vsync_in <= {4{~r[1]}};
        raw_field_in <= {4{r[2]}};
        hs_aligned_field_in <= {4{~r[2]}};
        @(posedge clk_in);
        #1;
        chk("hs", {9'h0, r[0] ~^ m[1]}, {9'h0, hsync_out[0]});
        chk("vs", {9'h0, (m[3] ? ~r[1] : r[1]) ~^ m[0]}, {9'h0, vsync_out[0]});
        chk("fld", {9'h0, (m[3] ? ~r[2] : r[2]) ^ m[2]}, {9'h0, field_flag_out[0]});
      end
    end
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h0e, {s[1:0], 6'h02});
      #1;
      chk("src", {7'h0, s == 0, s[1:0]}, {7'h0, steer_out[0].field_from_video,
        steer_out[0].field_accum_sel});
    end
    $display("sync test done");
    for (int k = 1; k < 7; k++)
    begin
      @(posedge clk_in);
      video_present_in <= {4{k[1]}};
      wr(8'h81, {k[0], k[2:0], 4'h0});
      #1;
      chk("std", {6'h0, k[2:0], k[0] | ~k[1]}, {6'h0, config_out[2].standard_code,
        steer_out[2].force_standard});
    end
    wr(8'h8d, 8'hf0);
    #1;
    chk("pll", {6'h0, 4'h7},
      {6'h0, steer_out[2].pll_auto_track, steer_out[2].pll_speed_eff});
    wr(8'h8d, 8'h00);
    #1;
    chk("pll", {6'h0, 4'h8},
      {6'h0, steer_out[2].pll_auto_track, steer_out[2].pll_speed_eff});
    $display("steer test done");
    wrap_up();
  end
endmodule
